// ---- hdl/snvc_defines.vh ----
`ifndef SNVC_DEFINES_VH
`define SNVC_DEFINES_VH

// Op-codes, sent most significant bit first
`define SNVC_OP_SET_PERMIT 8'h06
`define SNVC_OP_CLEAR_PERMIT 8'h04
`define SNVC_OP_STATUS_READ 8'h05
`define SNVC_OP_STATUS_WRITE 8'h01
`define SNVC_OP_ARRAY_READ 8'h03
`define SNVC_OP_ARRAY_WRITE 8'h02
`define SNVC_OP_FAST_FETCH 8'h0B
`define SNVC_OP_IDENT_READ 8'h9F
`define SNVC_OP_SLEEP 8'hB9

// Serial framing
`define SNVC_OPCODE_LAST 5'h07
`define SNVC_BYTE_LAST 5'h07
`define SNVC_ADDR_FIELD_LAST 5'h17

// Array geometry
`define SNVC_ADDR_BITS 17
`define SNVC_DEPTH 131072
`define SNVC_ADDR_MAX 17'h1FFFF
`define SNVC_ADDR_ZERO 17'h00000
`define SNVC_QUARTER_BASE 17'h18000
`define SNVC_HALF_BASE 17'h10000

// Status word layout
`define SNVC_STAT_GUARD_BIT 7
`define SNVC_STAT_SPARE_HI 6
`define SNVC_STAT_SPARE_LO 4
`define SNVC_STAT_BLOCK_HI 3
`define SNVC_STAT_BLOCK_LO 2
`define SNVC_STAT_PERMIT_BIT 1
`define SNVC_STAT_ZERO_BIT 0
`define SNVC_STAT_RESET 8'h00

// Block guard encodings
`define SNVC_GUARD_NONE 2'h0
`define SNVC_GUARD_QUARTER 2'h1
`define SNVC_GUARD_HALF 2'h2
`define SNVC_GUARD_ALL 2'h3

`endif

// ---- hdl/snvc_sync.v ----
module snvc_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // First stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      stable_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule // snvc_sync

// ---- hdl/snvc_array.v ----
module snvc_array #(
  parameter ADDR_W = 17,
  parameter DEPTH = 131072
) (
  input wire ref_clk,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] cells [0:DEPTH-1];

  // Array contents are nonvolatile, so reset leaves them alone
  always @(posedge ref_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end
endmodule // snvc_array

// ---- hdl/snvc_command_logic.v ----
`include "snvc_defines.vh"
// Functional notes
// RULE_01: Status bit 7 holds the status-write guard, written and read via status commands.
// RULE_02: Status bits 6 to 4 are spare stored bits, writable and readable.
// RULE_03: Status bits 3 and 2 hold block guard, writable and readable.
// RULE_04: Status bit 1 shows the permit latch; status write never changes it.
// RULE_05: Permit latch clears at reset, clear command, and frame end after writes.
// RULE_06: Status bit 0 always reads zero and cannot change.
// RULE_07: Every command starts with an 8-bit op-code; nine commands exist.
// RULE_08: Op-codes: set permit 06, clear permit 04, status read 05, write 01.
// RULE_09: Op-codes: read 03, write 02, fast 0B, ident 9F, sleep B9.
// RULE_10: The master sends only the nine defined op-codes.
// RULE_11: A frame ending before the op-code completes executes nothing.
// RULE_12: The master sets the permit latch in its own frame before writes.
// RULE_13: Status and array writes have no effect while the permit latch is clear.
// RULE_14: Status read shifts eight status bits out on falling edges.
// RULE_15: Status byte repeats for every further eight clocks while selected.
// RULE_16: Status write takes eight data bits into the writable status bits.
// RULE_17: Status write discards incoming bits for positions 1 and 0.
// RULE_18: The master holds the write-guard pin steady through a status write.
// RULE_19: Array read takes a 24-bit address, top 7 ignored, outputs byte.
// RULE_20: Array read auto-increments per byte and wraps to zero until deselect.
// RULE_21: Array write commits each byte when its eighth bit arrives.
// RULE_22: Array write auto-increments per byte and wraps until deselect.
// RULE_23: Input sampled on rising clock edges, output driven on falling edges.
// RULE_24: Deselected: output floats, other inputs ignored.
// RULE_25: Block guard 00 none, 01 18000-1FFFF, 10 10000-1FFFF, 11 all.
// RULE_26: Permit clear blocks all; status blocked when guard set and pin low.
// RULE_27: Low 17 address bits used; increment wraps 1FFFF to 00000.
module snvc_command_logic #(
  parameter ADDR_W = `SNVC_ADDR_BITS,
  parameter DEPTH = `SNVC_DEPTH
) (
  input wire ref_clk,
  input wire reset_n,
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  input wire write_guard_n,
  output wire sdo,
  output wire sdo_oe
);
  localparam [2:0] S_OPCODE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_STAT_RD = 3'h2;
  localparam [2:0] S_STAT_WR = 3'h3;
  localparam [2:0] S_ARR_RD = 3'h4;
  localparam [2:0] S_ARR_WR = 3'h5;
  localparam [2:0] S_IDLE_REST = 3'h6;

  wire [3:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  wire write_guard_n_s;
  wire [7:0] rd_data;

  reg sclk_prev_q;
  reg [2:0] state_q;
  reg [4:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [ADDR_W-1:0] addr_q;
  reg read_cmd_q;
  reg end_clear_q;
  reg guard_q;
  reg [2:0] spare_q;
  reg [1:0] block_q;
  reg permit_q;
  reg [7:0] tx_q;
  reg sdo_q;
  reg sdo_oe_q;
  reg wr_en_q;
  reg [ADDR_W-1:0] wr_addr_q;
  reg [7:0] wr_data_q;

  // Two stages on every pin, sclk included: it is sampled, not used as a clock
  snvc_sync #(
    .WIDTH(4),
    .RESET_VAL(4'hF)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({cs_n, sclk, sdi, write_guard_n}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign write_guard_n_s = pins_s[0];

  snvc_array #(
    .ADDR_W(ADDR_W),
    .DEPTH(DEPTH)
  ) u_array (
    .ref_clk(ref_clk),
    .wr_en(wr_en_q),
    .wr_addr(wr_addr_q),
    .wr_data(wr_data_q),
    .rd_addr(addr_q),
    .rd_data(rd_data)
  );

  function guarded;
    input [1:0] blk;
    input [ADDR_W-1:0] a;
    begin
      case (blk) // RULE_25
        `SNVC_GUARD_NONE: guarded = 1'b0;
        `SNVC_GUARD_QUARTER: guarded = (a >= `SNVC_QUARTER_BASE);
        `SNVC_GUARD_HALF: guarded = (a >= `SNVC_HALF_BASE);
        default: guarded = 1'b1;
      endcase
    end
  endfunction

  function [ADDR_W-1:0] next_addr;
    input [ADDR_W-1:0] a;
    begin
      if (a == `SNVC_ADDR_MAX) begin
        next_addr = `SNVC_ADDR_ZERO; // RULE_27
      end else begin
        next_addr = a + 1'b1;
      end
    end
  endfunction

  wire sclk_rise = sclk_s & ~sclk_prev_q; // RULE_23
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire [7:0] rx_byte = {shift_q[6:0], sdi_s};
  wire [7:0] status_word = {guard_q, spare_q, block_q, permit_q, 1'b0}; // RULE_06
  // Write-guard pin is sampled at commit; it must be steady for the frame
  wire status_ok = permit_q & ~(guard_q & ~write_guard_n_s); // RULE_26 RULE_18
  wire array_ok = permit_q & ~guarded(block_q, addr_q); // RULE_13 RULE_26
  wire [7:0] tx_src = (state_q == S_STAT_RD) ? status_word : rd_data;
  wire out_phase = (state_q == S_STAT_RD) | (state_q == S_ARR_RD);

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b1;
      state_q <= S_OPCODE;
      bit_cnt_q <= 5'h00;
      shift_q <= 8'h00;
      addr_q <= `SNVC_ADDR_ZERO;
      read_cmd_q <= 1'b0;
      end_clear_q <= 1'b0;
      guard_q <= 1'b0;
      spare_q <= 3'h0;
      block_q <= 2'h0;
      permit_q <= 1'b0; // RULE_05
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= `SNVC_ADDR_ZERO;
      wr_data_q <= 8'h00;
    end else begin
      sclk_prev_q <= sclk_s;
      wr_en_q <= 1'b0;
      if (cs_n_s) begin
        // Deselect aborts any partial op-code as well
        state_q <= S_OPCODE; // RULE_24 RULE_11
        bit_cnt_q <= 5'h00;
        sdo_oe_q <= 1'b0;
        sdo_q <= 1'b0;
        end_clear_q <= 1'b0;
        if (end_clear_q) begin
          permit_q <= 1'b0; // RULE_05
        end
      end else if (sclk_rise) begin
        shift_q <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 5'h01;
        case (state_q)
          S_OPCODE: begin
            if (bit_cnt_q == `SNVC_OPCODE_LAST) begin // RULE_07
              bit_cnt_q <= 5'h00;
              case (rx_byte) // RULE_08 RULE_09
                `SNVC_OP_SET_PERMIT: begin
                  permit_q <= 1'b1; // RULE_04
                  state_q <= S_IDLE_REST;
                end
                `SNVC_OP_CLEAR_PERMIT: begin
                  permit_q <= 1'b0; // RULE_05
                  state_q <= S_IDLE_REST;
                end
                `SNVC_OP_STATUS_READ: state_q <= S_STAT_RD;
                `SNVC_OP_STATUS_WRITE: begin
                  end_clear_q <= 1'b1;
                  state_q <= S_STAT_WR;
                end
                `SNVC_OP_ARRAY_READ: begin
                  read_cmd_q <= 1'b1;
                  state_q <= S_ADDR;
                end
                `SNVC_OP_ARRAY_WRITE: begin
                  read_cmd_q <= 1'b0;
                  end_clear_q <= 1'b1;
                  state_q <= S_ADDR;
                end
                // Fast fetch, ident read, sleep and undefined codes: no action
                default: state_q <= S_IDLE_REST; // RULE_10
              endcase
            end
          end
          S_ADDR: begin
            // Upper address bits fall off the top of the shift
            addr_q <= {addr_q[ADDR_W-2:0], sdi_s}; // RULE_19 RULE_21 RULE_27
            if (bit_cnt_q == `SNVC_ADDR_FIELD_LAST) begin
              bit_cnt_q <= 5'h00;
              state_q <= read_cmd_q ? S_ARR_RD : S_ARR_WR;
            end
          end
          S_STAT_WR: begin
            if (bit_cnt_q == `SNVC_BYTE_LAST) begin // RULE_16
              if (status_ok) begin // RULE_13
                guard_q <= rx_byte[`SNVC_STAT_GUARD_BIT]; // RULE_01
                spare_q <= rx_byte[`SNVC_STAT_SPARE_HI:`SNVC_STAT_SPARE_LO]; // RULE_02
                block_q <= rx_byte[`SNVC_STAT_BLOCK_HI:`SNVC_STAT_BLOCK_LO]; // RULE_03
              end
              // Bits 1 and 0 of the byte are dropped
              state_q <= S_IDLE_REST; // RULE_17
            end
          end
          S_STAT_RD: begin
            if (bit_cnt_q == `SNVC_BYTE_LAST) begin
              bit_cnt_q <= 5'h00; // RULE_15
            end
          end
          S_ARR_RD: begin
            if (bit_cnt_q == `SNVC_BYTE_LAST) begin
              bit_cnt_q <= 5'h00;
              addr_q <= next_addr(addr_q); // RULE_20
            end
          end
          S_ARR_WR: begin
            if (bit_cnt_q == `SNVC_BYTE_LAST) begin
              bit_cnt_q <= 5'h00;
              if (array_ok) begin
                wr_en_q <= 1'b1; // RULE_21
                wr_addr_q <= addr_q;
                wr_data_q <= rx_byte;
              end
              addr_q <= next_addr(addr_q); // RULE_22
            end
          end
          default: bit_cnt_q <= 5'h00;
        endcase
      end else if (sclk_fall && out_phase) begin
        // Sdi is not looked at while shifting out
        sdo_oe_q <= 1'b1; // RULE_14 RULE_19
        if (bit_cnt_q == 5'h00) begin
          sdo_q <= tx_src[7];
          tx_q <= {tx_src[6:0], 1'b0};
        end else begin
          sdo_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = sdo_oe_q;
endmodule // snvc_command_logic

// ---- tb/snvc_monitor.sv ----
module snvc_monitor #(
  parameter ADDR_W = 17,
  parameter DEPTH = 131072
) (
  input wire ref_clk,
  input wire reset_n,
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  input wire write_guard_n,
  input wire sdo,
  input wire sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q;
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  // Own edge finder, runs ahead of the design's synchroniser
  always @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (!reset_n || cs_n) begin
      cnt_q <= 6'h00;
      op_q <= 8'h00;
    end else if (sclk && !sclk_q) begin
      if (cnt_q != 6'h3F)
        cnt_q <= cnt_q + 6'h01;
      if (cnt_q < 6'h08)
        op_q <= {op_q[6:0], sdi};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence frame_end_s;
    $rose(cs_n);
  endsequence
  // A data step only: the drop to zero at deselect may come with the clock high
  sequence out_step_s;
    $changed(sdo) && sdo_oe;
  endsequence
  AST_FLOAT: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("sdo_oe high while deselected");
  AST_OE_DROP: assert property (frame_end_s |-> ##[1:4] !sdo_oe)
    else $error("sdo_oe not released after deselect");
  AST_OE_HOLD: assert property (sdo_oe && !cs_n |=> sdo_oe)
    else $error("sdo_oe dropped inside frame");
  AST_OE_CAUSE: assert property ($rose(sdo_oe) |-> !cs_n &&
    ((op_q == 8'h05 && cnt_q == 6'h08) || (op_q == 8'h03 && cnt_q == 6'h20)))
    else $error("output started at wrong point");
  AST_QUIET: assert property (cnt_q >= 6'h08 && op_q inside
    {8'h01, 8'h02, 8'h04, 8'h06, 8'h0B, 8'h9F, 8'hB9} |-> !sdo_oe)
    else $error("output driven for silent command");
  AST_SDO_FALL: assert property (out_step_s |-> $past(!sclk, 2))
    else $error("sdo changed away from falling edge");
  AST_SDO_HI: assert property (sdo_oe && $past(sdo_oe) && sclk &&
    $past(sclk) && $past(sclk, 2) |-> $stable(sdo))
    else $error("sdo moved while sclk high");
  AST_RST: assert property ($rose(reset_n) |-> !sdo_oe && !sdo)
    else $error("outputs active after reset");
endmodule // snvc_monitor

bind snvc_command_logic snvc_monitor #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) mon (.ref_clk(ref_clk),
  .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .write_guard_n(write_guard_n),
  .sdo(sdo), .sdo_oe(sdo_oe));

// ---- tb/snvc_master.sv ----
module snvc_master (
  input wire ref_clk,
  input wire cpol,
  input wire sdo,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sel();
    sclk = cpol;
    tick(1);
    cs_n = 1'b0;
    tick(4);
  endtask
  // Mode 0 or 3; clock stands at its idle level between frames
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (cpol)
        sclk = 1'b0;
      sdi = tx[i];
      tick(4);
      sclk = 1'b1;
      rx[i] = sdo;
      tick(4);
      if (!cpol)
        sclk = 1'b0;
    end
  endtask
  task automatic desel();
    tick(4);
    cs_n = 1'b1;
    // Released line must not keep its last bit
    sdi = ~sdi;
    tick(8);
  endtask
endmodule // snvc_master

// ---- tb/spi_nvram_command_logic_test.sv ----
module spi_nvram_command_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, write_guard_n, cpol;
  wire cs_n, sclk, sdi, sdo, sdo_oe;
  // Floating line reads as the inverse of sdo, which is held at zero while sdo_oe is low
  wire sdo_line = sdo_oe ? sdo : ~sdo;
  logic [7:0] r0, r1;
  int err_total, total_checks, cyc, oe_cnt, oe_base;
  logic [16:0] rows [5] = '{{8'hFF, 1'b1, 8'hFC}, {8'h03, 1'b1, 8'h00}, {8'h8E, 1'b1, 8'h8C},
    {8'h00, 1'b0, 8'h8C}, {8'h00, 1'b1, 8'h00}};
  logic [7:0] odd_ops [3] = '{8'h0B, 8'h9F, 8'hB9};
  snvc_command_logic uut (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .write_guard_n(write_guard_n), .sdo(sdo), .sdo_oe(sdo_oe));
  snvc_master m (.ref_clk(ref_clk), .cpol(cpol), .sdo(sdo_line), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (sdo_oe === 1'b1)
      oe_cnt++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic fr(input logic [7:0] op, input logic [23:0] a, input int na,
    input logic [7:0] d0, input logic [7:0] d1, input int nd);
    m.sel();
    m.xfer(op, 8, r0);
    for (int i = 0; i < na; i++)
      m.xfer(a[23-8*i -: 8], 8, r0);
    if (nd > 0)
      m.xfer(d0, 8, r0);
    if (nd > 1)
      m.xfer(d1, 8, r1);
    m.desel();
  endtask
  task automatic st(input string nm, input logic [7:0] e);
    fr(8'h05, 24'h0, 0, 8'h00, 8'h00, 1);
    chk(nm, e, r0);
  endtask
  task automatic rst();
    reset_n = 1'b0;
    m.tick(16);
    reset_n = 1'b1;
    m.tick(3);
  endtask
  initial begin
    write_guard_n = 1'b1;
    cpol = 1'b0;
    rst();
    foreach (rows[k]) begin
      write_guard_n = rows[k][8];
      fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
      fr(8'h01, 24'h0, 0, rows[k][16:9], 8'h00, 1);
      fr(8'h05, 24'h0, 0, 8'h00, 8'h00, 2);
      chk("status", rows[k][7:0], r0);
      chk("status again", rows[k][7:0], r1);
    end
    $display("end rows");
    // Mid-run reset also exercises the checker's reset handling
    rst();
    st("after reset", 8'h00);
    fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
    st("permit set", 8'h02);
    fr(8'h04, 24'h0, 0, 8'h00, 8'h00, 0);
    st("permit clear", 8'h00);
    m.sel();
    m.xfer(8'h06, 7, r0);
    m.desel();
    st("partial op", 8'h00);
    $display("end status");
    fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
    fr(8'h02, 24'h81FFFF, 3, 8'hAA, 8'h55, 2);
    fr(8'h03, 24'hFFFFFF, 3, 8'h00, 8'h00, 2);
    chk("top byte", 8'hAA, r0);
    chk("wrapped byte", 8'h55, r1);
    fr(8'h02, 24'h01FFFF, 3, 8'h00, 8'h00, 1);
    fr(8'h03, 24'h01FFFF, 3, 8'h00, 8'h00, 1);
    chk("no permit", 8'hAA, r0);
    fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
    fr(8'h02, 24'h017FFF, 3, 8'h33, 8'h44, 2);
    fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
    fr(8'h01, 24'h0, 0, 8'h04, 8'h00, 1);
    fr(8'h06, 24'h0, 0, 8'h00, 8'h00, 0);
    fr(8'h02, 24'h017FFF, 3, 8'h11, 8'h22, 2);
    fr(8'h03, 24'h017FFF, 3, 8'h00, 8'h00, 2);
    chk("open block", 8'h11, r0);
    chk("guarded block", 8'h44, r1);
    $display("end array");
    // Mode 3: clock idles high, first edge of a frame is a fall
    cpol = 1'b1;
    st("mode 3 status", 8'h04);
    fr(8'h03, 24'h017FFF, 3, 8'h00, 8'h00, 2);
    chk("mode 3 byte", 8'h11, r0);
    chk("mode 3 next", 8'h44, r1);
    cpol = 1'b0;
    $display("end mode 3");
    foreach (odd_ops[k]) begin
      oe_base = oe_cnt;
      fr(odd_ops[k], 24'h0, 3, 8'h00, 8'h00, 2);
      chk("float", 8'h00, {7'h00, oe_cnt != oe_base});
    end
    $display("end odd ops");
    test_done();
  end
endmodule // spi_nvram_command_logic_test
